// *** pcs_pkg.sv ***
package pcs_pkg;

  // register map, byte addresses on the apb bus
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  STAT_OFF      = 8'h04;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0100;

  // control register field positions
  localparam int CTL_RLV_EN    = 0;
  localparam int CTL_CEI_MODE  = 1;
  localparam int CTL_WIDE16    = 2;
  localparam int CTL_FAST_REC  = 3;
  localparam int CTL_LOW_LAT   = 4;
  localparam int CTL_INFER_EN  = 5;
  localparam int CTL_STEPS_LO  = 8;
  localparam int CTL_STEPS_HI  = 14;

  // run-length limit stepping per mode
  localparam int CEI_STEP       = 8;
  localparam int CEI_MAX_STEPS  = 64;
  localparam int PCIE_STEP      = 5;
  localparam int PCIE_MAX_STEPS = 32;
  localparam logic [1:0] RLV_HOLD_CYC = 2'h2;

  // timing, figures in ns and derived cycle counts at 40 MHz
  localparam int CLK_NS     = 25;
  localparam int RXDET_NS   = 1000;
  localparam int SETTLE_NS  = 500;
  localparam int RXDET_CYC  = (RXDET_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // word aligner thresholds
  localparam logic [1:0] SYNC_ACQ_COMMAS = 2'h3;
  localparam logic [2:0] SYNC_LOSS_ERRS  = 3'h4;

  // comma groups of both disparities
  localparam logic [9:0] COMMA_NEG = 10'h0FA;
  localparam logic [9:0] COMMA_POS = 10'h305;

  // idle inference windows in cycles, per select value
  localparam logic [11:0] INFER_WIN_1 = 12'h080;
  localparam logic [11:0] INFER_WIN_2 = 12'h280;
  localparam logic [11:0] INFER_WIN_3 = 12'h500;
  localparam logic [11:0] INFER_WIN_4 = 12'hFA0;

  // power-down states
  localparam logic [1:0] PD_P0  = 2'h0;
  localparam logic [1:0] PD_P1  = 2'h2;

  // receive status codes
  localparam logic [2:0] ST_OK       = 3'h0;
  localparam logic [2:0] ST_SKP_ADD  = 3'h1;
  localparam logic [2:0] ST_SKP_DEL  = 3'h2;
  localparam logic [2:0] ST_RX_DET   = 3'h3;
  localparam logic [2:0] ST_DEC_ERR  = 3'h4;
  localparam logic [2:0] ST_OVERFLOW = 3'h5;
  localparam logic [2:0] ST_UNDERFLW = 3'h6;
  localparam logic [2:0] ST_DISP_ERR = 3'h7;

  typedef enum logic [1:0] {SYNC_LOST, SYNC_ACQ, SYNC_OK} sync_state_t;
  typedef enum logic [1:0] {OP_IDLE, OP_RXDET, OP_SETTLE} phy_op_t;

endpackage

// *** run_length_check.sv ***
`timescale 1ns/10ps
`default_nettype none
module run_length_check (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic       bit_in,
  input  wire logic [9:0] limit,
  output logic            violation
);

  logic [9:0] run_ff;      // length of current run
  logic       prev_ff;     // last bit seen
  logic [1:0] hold_ff;     // cycles the flag still stands
  logic [9:0] nxt_run;
  logic [1:0] nxt_hold;
  wire        over;

  // restart on every transition, saturate rather than wrap
  assign nxt_run  = !enable ? 10'h000 :
                    (bit_in != prev_ff) ? 10'h001 :
                    (run_ff == 10'h3FF) ? run_ff : run_ff + 10'h001;
  assign over     = enable && (run_ff > limit);
  // stretch so a single-cycle overrun still shows for two cycles
  assign nxt_hold = !enable ? 2'h0 : over ? pcs_pkg::RLV_HOLD_CYC :
                    (hold_ff != 2'h0) ? hold_ff - 2'h1 : 2'h0;

  // counter and hold state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff    <= 10'h000;
      prev_ff   <= 1'b0;
      hold_ff   <= 2'h0;
      violation <= 1'b0;
    end else begin
      run_ff    <= nxt_run;
      prev_ff   <= bit_in;
      hold_ff   <= nxt_hold;
      violation <= (nxt_hold != 2'h0);
    end
  end

  a_rlv_min_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(violation) |-> violation[*2]) else $error("run flag shorter than two cycles");

  a_rlv_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !enable ##1 !enable |-> !violation) else $error("run flag while check off");

endmodule
`default_nettype wire

// *** pcs_pipe_ctrl.sv ***
// Contract
// - run overrun raises flag, two cycles minimum
// - cei limit 8 to 512 by eight
// - pcie limit 5 to 160 by five
// - low latency sets zero-offset fifo mode
// - fast recovery ignores external lock requests
// - idle inference follows three-bit select
// - automatic sync machine reports sync flag
// - status flags one bit per lane
// - pattern flag on comma in boundary
// - control flag high for twelve k groups
// - detect input: rx detect or loopback
// - force idle puts transmitter in idle
// - force disparity sends negative running disparity
// - tx polarity inverts every bit
// - three-bit encoded receive status output
// - receive valid marks valid data
// - idle output inferred or inverted detect
// - completion pulses one cycle
`timescale 1ns/10ps
`default_nettype none
module pcs_pipe_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_serial_pin,
  input  wire logic        sig_detect_pin,
  input  wire logic        rx_present_pin,
  input  wire logic [19:0] rx_code,
  input  wire logic        rx_code_valid,
  input  wire logic [1:0]  code_err,
  input  wire logic [1:0]  disp_err,
  input  wire logic        rm_inserted,
  input  wire logic        rm_deleted,
  input  wire logic        rm_full,
  input  wire logic        rm_empty,
  input  wire logic        lock_to_data_req,
  input  wire logic        lock_to_ref_req,
  input  wire logic [2:0]  infer_sel,
  input  wire logic [1:0]  powerdown,
  input  wire logic        rate_sel,
  input  wire logic        detect_loop,
  input  wire logic        force_idle,
  input  wire logic [1:0]  force_disp,
  input  wire logic        tx_invert,
  input  wire logic [19:0] tx_code,
  output logic             run_violation,
  output logic             rm_zero_offset,
  output logic             cdr_lock_to_data,
  output logic             cdr_lock_to_ref,
  output logic      [1:0]  sync_ok,
  output logic      [1:0]  pattern_hit,
  output logic      [1:0]  ctrl_code,
  output logic      [2:0]  rx_status,
  output logic             rx_valid,
  output logic             elec_idle,
  output logic             phy_done,
  output logic             rxdet_start,
  output logic             loopback_en,
  output logic             tx_elec_idle,
  output logic      [1:0]  tx_neg_disp,
  output logic      [19:0] tx_ser_code
);

  // true when a 10-bit group is one of the twelve k groups
  function automatic logic is_k(input logic [9:0] c);
    logic [5:0] hi;
    logic [3:0] lo;
    hi = c[9:4];
    lo = c[3:0];
    is_k = (hi == 6'h0F) || (hi == 6'h30) ||                  // k28.x, both disparities
           (((hi == 6'h3A) || (hi == 6'h36) || (hi == 6'h2E) || (hi == 6'h1E)) && lo == 4'h8) ||
           (((hi == 6'h05) || (hi == 6'h09) || (hi == 6'h11) || (hi == 6'h21)) && lo == 4'h7);
  endfunction

  // comma match on one lane
  function automatic logic is_comma(input logic [9:0] c);
    is_comma = (c == pcs_pkg::COMMA_NEG) || (c == pcs_pkg::COMMA_POS);
  endfunction

  // run-length limit from step count, clamped to the mode range
  function automatic logic [9:0] rl_limit(input logic cei, input logic [6:0] steps);
    logic [6:0] s;
    s = (steps == 7'h00) ? 7'h01 : steps;
    if (cei) begin
      if (s > 7'(pcs_pkg::CEI_MAX_STEPS)) s = 7'(pcs_pkg::CEI_MAX_STEPS);
      rl_limit = 10'(s * pcs_pkg::CEI_STEP);
    end else begin
      if (s > 7'(pcs_pkg::PCIE_MAX_STEPS)) s = 7'(pcs_pkg::PCIE_MAX_STEPS);
      rl_limit = 10'(s * pcs_pkg::PCIE_STEP);
    end
  endfunction

  // idle window for each select value, zero means no inference
  function automatic logic [11:0] infer_win(input logic [2:0] sel);
    case (sel)
      3'h1:    infer_win = pcs_pkg::INFER_WIN_1;
      3'h2:    infer_win = pcs_pkg::INFER_WIN_2;
      3'h3:    infer_win = pcs_pkg::INFER_WIN_3;
      3'h4:    infer_win = pcs_pkg::INFER_WIN_4;
      default: infer_win = 12'h000;
    endcase
  endfunction

  // pin synchronisers, stage one feeds only stage two
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  wire        ser_bit    = pin_s2_ff[0];
  wire        sd_sync    = pin_s2_ff[1];
  wire        rx_present = pin_s2_ff[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {rx_present_pin, sig_detect_pin, rx_serial_pin};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // apb slave, zero wait states
  logic [31:0] ctrl_ff;
  wire  access  = psel && penable;
  wire  hit_ctl = (paddr == pcs_pkg::CTRL_OFF);
  wire  hit_st  = (paddr == pcs_pkg::STAT_OFF);
  wire  wr_ctl  = access && pwrite && hit_ctl;
  wire  [31:0] stat_word = {24'h00_0000, rx_valid, rx_status, elec_idle, run_violation, sync_ok};
  assign pready  = 1'b1;
  assign pslverr = access && !(hit_ctl || hit_st);              // unmapped address
  wire  [31:0] rd_mux = pwrite ? 32'h0000_0000 :
                        hit_ctl ? ctrl_ff : hit_st ? stat_word : 32'h0000_0000;

  // read data taken in the setup cycle so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable) prdata <= rd_mux;               // status may lag by one cycle
  end

  // control register, unused bits read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_ff <= pcs_pkg::CTRL_RESET;
    else if (wr_ctl) ctrl_ff <= pwdata & 32'h0000_7F3F;
  end

  wire rlv_en   = ctrl_ff[pcs_pkg::CTL_RLV_EN];
  wire cei_mode = ctrl_ff[pcs_pkg::CTL_CEI_MODE];
  wire wide16   = ctrl_ff[pcs_pkg::CTL_WIDE16];
  wire fast_rec = ctrl_ff[pcs_pkg::CTL_FAST_REC];
  wire infer_en = ctrl_ff[pcs_pkg::CTL_INFER_EN];
  wire [6:0] steps = ctrl_ff[pcs_pkg::CTL_STEPS_HI:pcs_pkg::CTL_STEPS_LO];

  // run-length checker on the recovered serial stream
  run_length_check u_rlc (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (rlv_en),
    .bit_in    (ser_bit),
    .limit     (rl_limit(cei_mode, steps)),
    .violation (run_violation)
  );

  // lane decode, upper lane only counts in wide mode
  wire [1:0] lane_on  = {wide16, 1'b1};
  wire [1:0] comma_ln = {is_comma(rx_code[19:10]), is_comma(rx_code[9:0])} & lane_on;
  wire [1:0] k_ln     = {is_k(rx_code[19:10]), is_k(rx_code[9:0])} & lane_on;
  wire       any_comma = rx_code_valid && (comma_ln != 2'h0);
  wire       any_err   = rx_code_valid && ((code_err & lane_on) != 2'h0);

  // automatic word sync machine
  pcs_pkg::sync_state_t sync_ff, nxt_sync;
  logic [1:0] comma_cnt_ff, nxt_comma_cnt;
  logic [2:0] err_cnt_ff, nxt_err_cnt;

  always_comb begin
    nxt_sync      = sync_ff;
    nxt_comma_cnt = comma_cnt_ff;
    nxt_err_cnt   = err_cnt_ff;
    case (sync_ff)
      pcs_pkg::SYNC_LOST: begin                                // wait for first comma
        nxt_comma_cnt = 2'h0;
        nxt_err_cnt   = 3'h0;
        if (any_comma) begin
          nxt_sync      = pcs_pkg::SYNC_ACQ;
          nxt_comma_cnt = 2'h1;
        end
      end
      pcs_pkg::SYNC_ACQ: begin                                 // count clean commas
        if (any_err) nxt_sync = pcs_pkg::SYNC_LOST;
        else if (any_comma) begin
          nxt_comma_cnt = comma_cnt_ff + 2'h1;
          if (nxt_comma_cnt == pcs_pkg::SYNC_ACQ_COMMAS) nxt_sync = pcs_pkg::SYNC_OK;
        end
      end
      pcs_pkg::SYNC_OK: begin                                  // drop after repeated errors
        if (any_err) begin
          nxt_err_cnt = err_cnt_ff + 3'h1;
          if (nxt_err_cnt == pcs_pkg::SYNC_LOSS_ERRS) nxt_sync = pcs_pkg::SYNC_LOST;
        end
      end
      default: nxt_sync = pcs_pkg::SYNC_LOST;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff      <= pcs_pkg::SYNC_LOST;
      comma_cnt_ff <= 2'h0;
      err_cnt_ff   <= 3'h0;
    end else begin
      sync_ff      <= nxt_sync;
      comma_cnt_ff <= nxt_comma_cnt;
      err_cnt_ff   <= nxt_err_cnt;
    end
  end

  // lane flags, registered to line up with the data word
  wire synced = (sync_ff == pcs_pkg::SYNC_OK);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ok     <= 2'h0;
      pattern_hit <= 2'h0;
      ctrl_code   <= 2'h0;
      rx_valid    <= 1'b0;
    end else begin
      sync_ok     <= {2{synced}} & lane_on;
      pattern_hit <= rx_code_valid ? comma_ln : 2'h0;
      ctrl_code   <= rx_code_valid ? k_ln : 2'h0;
      rx_valid    <= synced && rx_code_valid;
    end
  end

  // idle inference: count cycles without a valid group
  logic [11:0] quiet_ff;
  wire  [11:0] win      = infer_win(infer_sel);
  wire         inferred = (win != 12'h000) && (quiet_ff >= win);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_ff <= 12'h000;
    else if (rx_code_valid) quiet_ff <= 12'h000;
    else if (quiet_ff != 12'hFFF) quiet_ff <= quiet_ff + 12'h001;
  end

  // cdr request steering, idle output and zero-offset fifo mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdr_lock_to_data <= 1'b0;
      cdr_lock_to_ref  <= 1'b1;
      elec_idle        <= 1'b1;
      rm_zero_offset   <= 1'b0;
    end else begin
      cdr_lock_to_data <= fast_rec ? sd_sync : lock_to_data_req;
      cdr_lock_to_ref  <= fast_rec ? !sd_sync : lock_to_ref_req;
      elec_idle        <= infer_en ? inferred : !sd_sync;
      rm_zero_offset   <= ctrl_ff[pcs_pkg::CTL_LOW_LAT];
    end
  end

  // phy operations: receiver detect and settle after state changes
  pcs_pkg::phy_op_t op_ff, nxt_op;
  logic [5:0] tmr_ff, nxt_tmr;
  logic [1:0] pd_prev_ff;
  logic       rate_prev_ff;
  logic       det_prev_ff;
  wire det_req    = detect_loop && !det_prev_ff && (powerdown == pcs_pkg::PD_P1);
  wire pd_change  = (powerdown != pd_prev_ff) || (rate_sel != rate_prev_ff);
  wire op_end     = (op_ff != pcs_pkg::OP_IDLE) && (tmr_ff == 6'h01);
  wire rxdet_hit  = op_end && (op_ff == pcs_pkg::OP_RXDET);

  always_comb begin
    nxt_op  = op_ff;
    nxt_tmr = tmr_ff;
    case (op_ff)
      pcs_pkg::OP_IDLE: begin
        if (det_req) begin
          nxt_op  = pcs_pkg::OP_RXDET;
          nxt_tmr = 6'(pcs_pkg::RXDET_CYC);
        end else if (pd_change) begin
          nxt_op  = pcs_pkg::OP_SETTLE;
          nxt_tmr = 6'(pcs_pkg::SETTLE_CYC);
        end
      end
      pcs_pkg::OP_RXDET, pcs_pkg::OP_SETTLE: begin             // run timer to one
        nxt_tmr = tmr_ff - 6'h01;
        if (op_end) nxt_op = pcs_pkg::OP_IDLE;
      end
      default: nxt_op = pcs_pkg::OP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_ff        <= pcs_pkg::OP_IDLE;
      tmr_ff       <= 6'h00;
      pd_prev_ff   <= pcs_pkg::PD_P0;
      rate_prev_ff <= 1'b0;
      det_prev_ff  <= 1'b0;
      phy_done     <= 1'b0;
      rxdet_start  <= 1'b0;
    end else begin
      op_ff        <= nxt_op;
      tmr_ff       <= nxt_tmr;
      pd_prev_ff   <= powerdown;                               // change seen in idle only
      rate_prev_ff <= rate_sel;
      det_prev_ff  <= detect_loop;
      phy_done     <= op_end;
      rxdet_start  <= (op_ff == pcs_pkg::OP_IDLE) && det_req;
    end
  end

  // receive status encoding, detect result first, then errors
  logic [2:0] nxt_status;
  assign nxt_status = (rxdet_hit && rx_present) ? pcs_pkg::ST_RX_DET :
                      any_err                   ? pcs_pkg::ST_DEC_ERR :
                      ((disp_err & lane_on) != 2'h0) ? pcs_pkg::ST_DISP_ERR :
                      rm_full                   ? pcs_pkg::ST_OVERFLOW :
                      rm_empty                  ? pcs_pkg::ST_UNDERFLW :
                      rm_deleted                ? pcs_pkg::ST_SKP_DEL :
                      rm_inserted               ? pcs_pkg::ST_SKP_ADD : pcs_pkg::ST_OK;

  // receive status and transmit side controls, one stage before the serializer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_status    <= pcs_pkg::ST_OK;
      loopback_en  <= 1'b0;
      tx_elec_idle <= 1'b1;
      tx_neg_disp  <= 2'h0;
      tx_ser_code  <= 20'h0_0000;
    end else begin
      rx_status    <= nxt_status;
      loopback_en  <= detect_loop && (powerdown == pcs_pkg::PD_P0);
      tx_elec_idle <= force_idle;
      tx_neg_disp  <= force_disp & lane_on;
      tx_ser_code  <= tx_invert ? ~tx_code : tx_code;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_det_begin;
    rxdet_start;
  endsequence
  sequence s_det_end;
    ##[40:42] phy_done;
  endsequence

  a_rxdet_done: assert property (s_det_begin |-> s_det_end)
    else $error("receiver detect did not complete on time");
  a_done_pulse: assert property (phy_done |=> !phy_done)
    else $error("completion longer than one cycle");
  a_fast_cdr: assert property (fast_rec ##1 fast_rec |-> cdr_lock_to_ref == !cdr_lock_to_data)
    else $error("external lock request leaked in fast mode");
  a_idle_sigdet: assert property (!infer_en ##1 !infer_en |-> elec_idle == !$past(sd_sync))
    else $error("idle output not inverted detect");
  a_force_idle: assert property (force_idle |=> tx_elec_idle)
    else $error("force idle ignored");
  a_k28_flag: assert property (rx_code_valid && rx_code[9:0] == pcs_pkg::COMMA_NEG |=> ctrl_code[0] && pattern_hit[0])
    else $error("comma not flagged");
  a_valid_sync: assert property (rx_valid |-> sync_ok[0])
    else $error("valid without sync");
  a_narrow_lane: assert property (!wide16 ##1 !wide16 |-> sync_ok[1] == 1'b0 && ctrl_code[1] == 1'b0)
    else $error("upper lane active in narrow mode");
  a_status_err: assert property (any_err && !rxdet_hit |=> rx_status == pcs_pkg::ST_DEC_ERR)
    else $error("decode error not reported");
  a_tx_invert: assert property (tx_invert ##1 tx_invert |-> tx_ser_code == ~$past(tx_code))
    else $error("tx word not inverted");

endmodule
`default_nettype wire

// *** fabric_mac_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module fabric_mac_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        wide,
  output logic      [19:0] tx_code,
  output logic      [1:0]  force_disp
);
  logic [9:0]  cnt_ff;  // filler, never repeats the last word
  logic [19:0] code_ff; // word on the transmit data lines
  logic [1:0]  disp_ff; // force bits beside that word
  assign tx_code    = code_ff;
  assign force_disp = disp_ff;
  // comma and force bits go out in one cycle; filler changes every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 10'h000;
      code_ff <= 20'h0_0000;
      disp_ff <= 2'b00;
    end else begin
      cnt_ff <= cnt_ff + 10'h001;
      if (start) begin
        code_ff <= {10'h2AA, pcs_pkg::COMMA_NEG};
        disp_ff <= wide ? 2'b01 : 2'b11;
      end else begin
        code_ff <= {~cnt_ff, cnt_ff};
        disp_ff <= 2'b00;
      end
    end
  end
endmodule
`default_nettype wire

// *** test_serdes_pcs_pipe_status_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_serdes_pcs_pipe_status_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, start, wide;
  logic rx_serial_pin, sig_detect_pin, rx_present_pin, rx_code_valid, rate_sel;
  logic rm_inserted, rm_deleted, rm_full, rm_empty, lock_to_data_req, lock_to_ref_req;
  logic detect_loop, force_idle, tx_invert, run_violation, rm_zero_offset, rx_valid;
  logic cdr_lock_to_data, cdr_lock_to_ref, elec_idle, phy_done, rxdet_start;
  logic loopback_en, tx_elec_idle;
  logic [1:0]  code_err, disp_err, powerdown, force_disp, sync_ok, pattern_hit;
  logic [1:0]  ctrl_code, tx_neg_disp;
  logic [2:0]  infer_sel, rx_status;
  logic [7:0]  paddr;
  logic [19:0] rx_code, tx_code, tx_ser_code;
  logic [31:0] pwdata, prdata, rd;
  int          fails, n_compared;
  pcs_pipe_ctrl u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .rx_serial_pin, .sig_detect_pin, .rx_present_pin,
    .rx_code, .rx_code_valid, .code_err, .disp_err, .rm_inserted, .rm_deleted,
    .rm_full, .rm_empty, .lock_to_data_req, .lock_to_ref_req, .infer_sel, .powerdown,
    .rate_sel, .detect_loop, .force_idle, .force_disp, .tx_invert, .tx_code,
    .run_violation, .rm_zero_offset, .cdr_lock_to_data, .cdr_lock_to_ref, .sync_ok,
    .pattern_hit, .ctrl_code, .rx_status, .rx_valid, .elec_idle, .phy_done,
    .rxdet_start, .loopback_en, .tx_elec_idle, .tx_neg_disp, .tx_ser_code);
  fabric_mac_model u_mac (.pclk, .presetn, .start, .wide, .tx_code, .force_disp);
  // clock, 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // settle one step past the n-th edge
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // one apb transfer, result lands in rd and err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs;
    #1;
    chk("ref_rst", 1, cdr_lock_to_ref);
    chk("txidle_rst", 1, tx_elec_idle);
    apb(0, pcs_pkg::CTRL_OFF, 0);
    chk("ctrl_rst", pcs_pkg::CTRL_RESET, rd);
    apb(0, pcs_pkg::STAT_OFF, 0);
    chk("stat_rst", 32'h0000_0008, rd);
    apb(1, pcs_pkg::CTRL_OFF, 32'hFFFF_FFFF);
    apb(0, pcs_pkg::CTRL_OFF, 0);
    chk("ctrl_mask", 32'h0000_7F3F, rd);
    apb(0, 8'h08, 0);
    chk("unmapped_err", 1, err);
    chk("unmapped_rd", 0, rd);
  endtask
  // runs of exactly lim bits pass, a longer run trips the flag
  task automatic t_rlv(input logic [31:0] c, input int lim);
    int i;
    logic seen, base;
    apb(1, pcs_pkg::CTRL_OFF, c);
    repeat (8) begin
      @(posedge pclk);
      rx_serial_pin <= ~rx_serial_pin;
    end
    base = rx_serial_pin;
    seen = 1'b0;
    for (i = 0; i < 3 * lim + 8; i++) begin
      @(posedge pclk);
      rx_serial_pin <= base ^ 1'((i / lim) % 2);
      #1;
      if (i > 3 && run_violation !== 1'b0) seen = 1'b1;
    end
    chk("rlv_short", 0, seen);
    i = 0;
    while (run_violation !== 1'b1 && i < lim + 12) begin
      cyc(1);
      i++;
    end
    chk("rlv_long", 1, run_violation);
    cyc(1);
    chk("rlv_hold", 1, run_violation);
  endtask
  task automatic t_rx;
    logic [9:0] kt [12] = '{10'h0F4, 10'h0F9, 10'h0F5, 10'h0F3, 10'h0F2, 10'h0FA,
                            10'h0F6, 10'h0F8, 10'h3A8, 10'h368, 10'h2E8, 10'h1E8};
    apb(1, pcs_pkg::CTRL_OFF, 32'h0000_0100);
    foreach (kt[k]) begin
      @(posedge pclk);
      rx_code <= {10'h2AA, kt[k]};
      rx_code_valid <= 1'b1;
      cyc(1);
      chk("ctrl_code", 2'b01, ctrl_code);
    end
    chk("rx_valid_acq", 0, rx_valid);
    @(posedge pclk);
    rx_code <= {10'h2AA, pcs_pkg::COMMA_NEG};
    cyc(4);
    chk("pattern", 2'b01, pattern_hit);
    chk("sync", 2'b01, sync_ok);
    chk("rx_valid", 1, rx_valid);
    @(posedge pclk);
    rx_code <= {10'h2AA, 10'h2AA};
    cyc(1);
    chk("data_flags", 0, {pattern_hit, ctrl_code});
    apb(1, pcs_pkg::CTRL_OFF, 32'h0000_0104);
    @(posedge pclk);
    rx_code <= {pcs_pkg::COMMA_NEG, pcs_pkg::COMMA_NEG};
    cyc(2);
    chk("wide_ctrl", 2'b11, ctrl_code);
  endtask
  // {code, disp, full, empty, deleted, inserted} then expected code
  task automatic t_stat;
    logic [8:0] tb [7] = '{{6'b110000, pcs_pkg::ST_DEC_ERR}, {6'b011000, pcs_pkg::ST_DISP_ERR},
      {6'b001100, pcs_pkg::ST_OVERFLOW}, {6'b000110, pcs_pkg::ST_UNDERFLW},
      {6'b000011, pcs_pkg::ST_SKP_DEL}, {6'b000001, pcs_pkg::ST_SKP_ADD}, {6'b0, pcs_pkg::ST_OK}};
    foreach (tb[i]) begin
      @(posedge pclk);
      {code_err[0], disp_err[0], rm_full, rm_empty, rm_deleted, rm_inserted} <= tb[i][8:3];
      cyc(2);
      chk("rx_status", tb[i][2:0], rx_status);
    end
  endtask
  task automatic t_cdr;
    @(posedge pclk);
    sig_detect_pin <= 1'b1;
    lock_to_ref_req <= 1'b1;
    apb(1, pcs_pkg::CTRL_OFF, 32'h0000_0118);
    cyc(6);
    chk("fast_cdr", 2'b10, {cdr_lock_to_data, cdr_lock_to_ref});
    chk("zero_off", 1, rm_zero_offset);
    chk("idle_inv", 0, elec_idle);
    apb(1, pcs_pkg::CTRL_OFF, 32'h0000_0100);
    cyc(3);
    chk("ext_cdr", 2'b01, {cdr_lock_to_data, cdr_lock_to_ref});
  endtask
  task automatic t_infer;
    int n;
    n = 0;
    @(posedge pclk);
    rx_code_valid <= 1'b0;
    infer_sel <= 3'h1;
    apb(1, pcs_pkg::CTRL_OFF, 32'h0000_0120);
    while (elec_idle !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("infer_win", 1, n > 100 && n < 135);
    @(posedge pclk);
    infer_sel <= 3'h0;
    cyc(2);
    chk("infer_off", 0, elec_idle);
  endtask
  task automatic wait_done(input int lo, input int hi, input logic [2:0] st);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (phy_done !== 1'b1 && n < 60);
    chk("done_time", 1, n >= lo && n <= hi);
    chk("done_status", st, rx_status);
    cyc(1);
    chk("done_pulse", 0, phy_done);
  endtask
  task automatic t_phy;
    @(posedge pclk);
    powerdown <= pcs_pkg::PD_P1;
    rx_present_pin <= 1'b1;
    wait_done(19, 23, pcs_pkg::ST_OK);
    @(posedge pclk);
    rate_sel <= 1'b1;
    wait_done(19, 23, pcs_pkg::ST_OK);
    @(posedge pclk);
    detect_loop <= 1'b1;
    cyc(1);
    chk("rxdet_start", 1, rxdet_start);
    wait_done(37, 42, pcs_pkg::ST_RX_DET);
    @(posedge pclk);
    detect_loop <= 1'b0;
    powerdown <= pcs_pkg::PD_P0;
    wait_done(19, 23, pcs_pkg::ST_OK);
    @(posedge pclk);
    detect_loop <= 1'b1;
    cyc(2);
    chk("loopback", 2'b10, {loopback_en, rxdet_start});
  endtask
  task automatic t_tx(input logic w);
    logic [19:0] e;
    apb(1, pcs_pkg::CTRL_OFF, w ? 32'h0000_0104 : 32'h0000_0100);
    @(posedge pclk);
    wide <= w;
    start <= 1'b1;
    force_idle <= ~w;
    tx_invert <= ~w;
    @(posedge pclk);
    start <= 1'b0;
    #1;
    e = w ? tx_code : ~tx_code;
    cyc(1);
    chk("tx_word", e, tx_ser_code);
    chk("neg_disp", 2'b01, tx_neg_disp);
    chk("tx_idle", !w, tx_elec_idle);
  endtask
  task automatic print_verdict;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(25 * 30000);
    fails++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rx_serial_pin, sig_detect_pin} = '0;
    {rx_present_pin, rx_code, rx_code_valid, code_err, disp_err, rm_inserted} = '0;
    {rm_deleted, rm_full, rm_empty, lock_to_data_req, lock_to_ref_req, infer_sel} = '0;
    {powerdown, rate_sel, detect_loop, force_idle, tx_invert, start, wide} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rlv(32'h0000_0101, 5);
    t_rlv(32'h0000_2001, 160);
    t_rlv(32'h0000_0103, 8);
    t_rlv(32'h0000_4003, 512);
    t_rx();
    t_stat();
    t_cdr();
    t_infer();
    t_phy();
    t_tx(1'b0);
    t_tx(1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
